//--- rtl/uht_host_token.sv
// host token issuing block: token register, issue engine, frame timer, irq
//
// Function
// - decode three-bit code, seven used, reserved idle
// - on finish clear code, set done flag
// - irq when done flag and enable set
// - toggle picks DATA0/DATA1, mismatch flags error
// - frame marker ignores toggle and endpoint
// - no token sent while disconnected
// - endpoint field addresses the remote endpoint
// - soft reset zeroes toggle, code, endpoint
// - no preamble packet ever produced
// - frame marker every millisecond, frame number increments
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
module uht_host_token
	import uht_pkg::*;
#(
	parameter int FRAME_CNT = FRAME_CYCLES
)
(
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite register bus
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// token link towards the packet engine
	output uht_token_t       tok,
	output logic             tok_valid,
	input  wire logic        tok_ready,
	input  wire logic        tok_done,
	input  wire logic [1:0]  tok_hs,
	input  wire logic        tok_rx_tog_valid,
	input  wire logic        tok_rx_tog,
	// port status and unit signals
	input  wire logic        connect_status,
	output logic             frame_marker_busy,
	output logic [10:0]      frame_number,
	output logic             irq
);

	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} uht_state_t;

	uht_state_t  st_r;
	logic        tog_r;
	logic [2:0]  code_r;
	logic [3:0]  ep_r;
	logic [1:0]  status_r;
	logic [1:0]  mask_r;
	logic [1:0]  hs_r;
	logic        host_r;
	logic        sof_on_r;
	logic        sof_pend_r;
	logic        periodic_r;
	logic [16:0] timer_r;
	uht_wr_t     wr;
	logic        wr_en;
	uht_kind_t   kind;
	logic        kind_in;
	logic        kind_sof;
	logic        kind_op;
	uht_kind_t   wkind;
	logic        wkind_sof;
	logic        wkind_op;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rd_data;

	localparam logic [16:0] FRAME_RELOAD = 17'(FRAME_CNT - 1);

	// register bus front end
	uht_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.awaddr  (s_awaddr),
		.awvalid (s_awvalid),
		.awready (s_awready),
		.wdata   (s_wdata),
		.wstrb   (s_wstrb),
		.wvalid  (s_wvalid),
		.wready  (s_wready),
		.bresp   (s_bresp),
		.bvalid  (s_bvalid),
		.bready  (s_bready),
		.arvalid (s_arvalid),
		.arready (s_arready),
		.rdata   (s_rdata),
		.rresp   (s_rresp),
		.rvalid  (s_rvalid),
		.rready  (s_rready),
		.wr      (wr),
		.wr_en   (wr_en),
		.wr_ok   (wr_ok),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	// decoders for the held code and for the code being written
	uht_token_decode u_dec (
		.code   (code_r),
		.kind   (kind),
		.is_in  (kind_in),
		.is_sof (kind_sof),
		.is_op  (kind_op)
	);

	uht_token_decode u_wdec (
		.code   (wr.data[CODE_LSB+2:CODE_LSB]),
		.kind   (wkind),
		.is_in  (),
		.is_sof (wkind_sof),
		.is_op  (wkind_op)
	);

	// address decode, unmapped offsets answer slverr
	wire logic hit_token  = (wr.addr == OFS_TOKEN);
	wire logic hit_status = (wr.addr == OFS_STATUS);
	wire logic hit_mask   = (wr.addr == OFS_MASK);
	wire logic hit_ctrl   = (wr.addr == OFS_CTRL);
	wire logic hit_frame  = (wr.addr == OFS_FRAME);
	wire logic hit_state  = (wr.addr == OFS_STATE);
	assign wr_ok = hit_token || hit_status || hit_mask || hit_ctrl || hit_frame || hit_state;
	wire logic lo_wr = wr_en && wr.strb[0];

	// read mux on the live read address
	wire logic [31:0] rd_token  = {24'h000000, tog_r, code_r, ep_r};
	wire logic [31:0] rd_state  = {27'h0000000, host_r, hs_r, frame_marker_busy, connect_status};
	wire logic [31:0] rd_frame  = {21'h000000, frame_number};
	assign rd_ok     = (s_araddr == OFS_TOKEN) || (s_araddr == OFS_STATUS) ||
	                              (s_araddr == OFS_MASK) || (s_araddr == OFS_STATE) ||
	                              (s_araddr == OFS_CTRL) || (s_araddr == OFS_FRAME);
	assign rd_data   = (s_araddr == OFS_TOKEN)  ? rd_token :
	                              (s_araddr == OFS_STATUS) ? {30'h00000000, status_r} :
	                              (s_araddr == OFS_MASK)   ? {30'h00000000, mask_r} :
	                              (s_araddr == OFS_STATE)  ? rd_state :
	                              (s_araddr == OFS_CTRL)   ? {30'h00000000, host_r, 1'b0} :
	                              (s_araddr == OFS_FRAME)  ? rd_frame : 32'h0000_0000;

	// control strobes
	wire logic soft_rst  = lo_wr && hit_ctrl && wr.data[CTRL_RST];
	// writes refused while an operation is held, outside host mode, or a repeat marker start
	wire logic tok_wr    = lo_wr && hit_token && (code_r == CODE_NONE) && host_r &&
	                       !(wkind_sof && sof_on_r);
	wire logic idle_pick = ce && (st_r == ST_IDLE);
	wire logic pick_sof  = idle_pick && sof_pend_r && connect_status;
	wire logic pick_code = idle_pick && !sof_pend_r && kind_op && connect_status;
	wire logic drop_code = idle_pick && kind_op && !connect_status;
	wire logic fin       = ce && (st_r == ST_WAIT) && tok_done;
	wire logic fin_sof   = fin && (periodic_r || kind_sof);
	wire logic fin_code  = fin && !periodic_r;
	wire logic tog_err   = fin_code && kind_in && tok_rx_tog_valid && (tok_rx_tog != tog_r);

	// sticky status: hardware set wins over write-one-to-clear
	wire logic [1:0] st_clr = (lo_wr && hit_status) ? wr.data[1:0] : 2'h0;
	wire logic [1:0] st_set = {tog_err, fin_code};
	wire logic [1:0] status_nxt = (status_r & ~st_clr) | st_set;

	// token register: written fields, code cleared at finish or on a drop, all fields cleared by soft reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn || (ce && soft_rst))
		begin
			tog_r  <= 1'b0;
			code_r <= CODE_NONE;
			ep_r   <= 4'h0;
		end
		else if (ce)
		begin
			if (tok_wr)
			begin
				tog_r  <= wr.data[TOG_BIT];
				code_r <= wkind_op ? wr.data[CODE_LSB+2:CODE_LSB] : CODE_NONE;
				ep_r   <= wr.data[EP_LSB+3:EP_LSB];
			end
			else if (fin_code || drop_code)
				code_r <= CODE_NONE;
		end
	end

	// status, mask, mode and handshake capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_r <= STAT_RST;
			mask_r   <= STAT_RST;
			host_r   <= 1'b0;
			hs_r     <= 2'h0;
			irq      <= 1'b0;
		end
		else if (ce)
		begin
			status_r <= status_nxt;
			if (lo_wr && hit_mask)
				mask_r <= wr.data[1:0];
			if (lo_wr && hit_ctrl)
				host_r <= wr.data[CTRL_HOST];
			if (fin_code)
				hs_r <= tok_hs;
			irq <= |(status_r & mask_r);
		end
	end

	// issue engine: offer the token, then wait for the link to report it done
	always_ff @(posedge aclk)
	begin
		if (!aresetn || (ce && soft_rst))
		begin
			st_r       <= ST_IDLE;
			tok_valid  <= 1'b0;
			tok        <= '0;
			periodic_r <= 1'b0;
		end
		else if (ce)
		begin
			case (st_r)
				ST_IDLE:
				begin
					if (pick_sof || pick_code)
					begin
						st_r       <= ST_SEND;
						tok_valid  <= 1'b1;
						periodic_r <= pick_sof;
						tok.kind   <= pick_sof ? TK_SOF : kind;
						// marker carries neither toggle nor endpoint
						tok.endpoint <= (pick_sof || kind_sof) ? 4'h0 : ep_r;
						tok.data1    <= (pick_sof || kind_sof) ? 1'b0 : tog_r;
					end
				end
				ST_SEND:
				begin
					if (tok_ready)
					begin
						tok_valid <= 1'b0;
						st_r      <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (tok_done)
						st_r <= ST_IDLE;
				end
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// frame timer: a pending marker waits for the engine to go idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || (ce && soft_rst))
		begin
			sof_on_r     <= 1'b0;
			sof_pend_r   <= 1'b0;
			timer_r      <= 17'h00000;
			frame_number <= FRAME_RST;
		end
		else if (ce)
		begin
			if (fin_sof)
				frame_number <= frame_number + 11'h001;
			else if (lo_wr && hit_frame && !frame_marker_busy)
				frame_number <= {wr.data[10:8] & {3{wr.strb[1]}}, wr.data[7:0]};
			if (fin_code && kind_sof)
			begin
				sof_on_r <= 1'b1;
				timer_r  <= FRAME_RELOAD;
			end
			else if (sof_on_r)
				timer_r <= (timer_r == 17'h00000) ? FRAME_RELOAD : timer_r - 17'h00001;
			if (sof_on_r && (timer_r == 17'h00000))
				sof_pend_r <= 1'b1;
			else if (pick_sof || (idle_pick && !connect_status))
				sof_pend_r <= 1'b0;
		end
	end

	// busy while a marker is queued or on the link
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			frame_marker_busy <= 1'b0;
		else if (ce)
			frame_marker_busy <= sof_pend_r || ((st_r != ST_IDLE) && (periodic_r || kind_sof));
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	code_clear_a: assert property (fin_code && !soft_rst |=> code_r == CODE_NONE && status_r[STAT_DONE])
		else $error("code not cleared or done flag not set at finish");
	irq_level_a: assert property (ce && status_r[STAT_DONE] && mask_r[STAT_DONE] |=> irq)
		else $error("irq missing for enabled done flag");
	irq_quiet_a: assert property (ce && !(|(status_r & mask_r)) |=> !irq)
		else $error("irq without an enabled flag");
	tog_err_a: assert property (tog_err |=> status_r[STAT_TERR])
		else $error("toggle mismatch not flagged");
	sof_fields_a: assert property (tok_valid && tok.kind == TK_SOF |-> tok.endpoint == 4'h0 && !tok.data1)
		else $error("marker token carries toggle or endpoint");
	no_disc_send_a: assert property (ce && st_r == ST_IDLE && !connect_status |=> !tok_valid)
		else $error("token offered while disconnected");
	ep_select_a: assert property (pick_code && !kind_sof && !soft_rst |=> tok.endpoint == $past(ep_r))
		else $error("token endpoint differs from register");
	soft_rst_a: assert property (ce && soft_rst |=> code_r == CODE_NONE && !tog_r && ep_r == 4'h0)
		else $error("soft reset left token fields set");
	frame_inc_a: assert property (fin_sof && !soft_rst |=> frame_number == $past(frame_number) + 11'h001)
		else $error("frame number not incremented after marker");
	rsvd_idle_a: assert property (tok_wr && !wkind_op |=> code_r == CODE_NONE ##1 !status_r[STAT_DONE] || !$past(status_r[STAT_DONE], 2) )
		else $error("idle write produced activity");
	no_pre_a: assert property (tok_valid |-> tok.kind != TK_NONE)
		else $error("token of no known kind offered");

	in_done_c: cover property (fin_code && kind_in);
	periodic_c: cover property (fin && periodic_r);
	irq_rise_c: cover property (!irq ##1 irq);
	disc_drop_c: cover property (drop_code);

endmodule

//--- rtl/uht_pkg.sv
// shared constants, register map and carrier types of the host token issuing block
package uht_pkg;

	// clock and frame timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FRAME_PERIOD_NS = 1000000;
	localparam int FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [7:0] OFS_TOKEN  = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK   = 8'h08;
	localparam logic [7:0] OFS_STATE  = 8'h0c;
	localparam logic [7:0] OFS_CTRL   = 8'h10;
	localparam logic [7:0] OFS_FRAME  = 8'h14;

	// field positions
	localparam int TOG_BIT      = 7;
	localparam int CODE_LSB     = 4;
	localparam int EP_LSB       = 0;
	localparam int STAT_DONE    = 0;
	localparam int STAT_TERR    = 1;
	localparam int CTRL_RST     = 0;
	localparam int CTRL_HOST    = 1;
	localparam int STATE_CONN   = 0;
	localparam int STATE_BUSY   = 1;
	localparam int STATE_HS_LSB = 2;

	// reset values
	localparam logic [7:0]  TOKEN_RST = 8'h00;
	localparam logic [10:0] FRAME_RST = 11'h000;
	localparam logic [1:0]  STAT_RST  = 2'h0;

	// token codes
	localparam logic [2:0] CODE_NONE    = 3'h0;
	localparam logic [2:0] CODE_SETUP   = 3'h1;
	localparam logic [2:0] CODE_IN      = 3'h2;
	localparam logic [2:0] CODE_OUT     = 3'h3;
	localparam logic [2:0] CODE_SOF     = 3'h4;
	localparam logic [2:0] CODE_ISO_IN  = 3'h5;
	localparam logic [2:0] CODE_ISO_OUT = 3'h6;
	localparam logic [2:0] CODE_RSVD    = 3'h7;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		TK_NONE, TK_SETUP, TK_IN, TK_OUT, TK_SOF, TK_ISO_IN, TK_ISO_OUT
	} uht_kind_t;

	// one token as offered to the link
	typedef struct packed {
		uht_kind_t  kind;
		logic [3:0] endpoint;
		logic       data1;
	} uht_token_t;

	// one register write as handed over by the bus slave
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} uht_wr_t;

endpackage

//--- rtl/uht_token_decode.sv
// token code decoder of the host token issuing block
module uht_token_decode
	import uht_pkg::*;
(
	// code in
	input  wire logic [2:0] code,
	// decoded kind
	output uht_kind_t       kind,
	output logic            is_in,
	output logic            is_sof,
	output logic            is_op
);

	// reserved code maps to no action, no preamble kind exists at all
	assign kind = (code == CODE_SETUP)   ? TK_SETUP :
	              (code == CODE_IN)      ? TK_IN :
	              (code == CODE_OUT)     ? TK_OUT :
	              (code == CODE_SOF)     ? TK_SOF :
	              (code == CODE_ISO_IN)  ? TK_ISO_IN :
	              (code == CODE_ISO_OUT) ? TK_ISO_OUT : TK_NONE;

	// class flags
	assign is_in  = (kind == TK_IN) || (kind == TK_ISO_IN);
	assign is_sof = (kind == TK_SOF);
	assign is_op  = (kind != TK_NONE);

endmodule

//--- rtl/uht_axil_slave.sv
// axi4-lite slave front end: single outstanding write and read
module uht_axil_slave
	import uht_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read channels
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// register side
	output uht_wr_t          wr,
	output logic             wr_en,
	input  wire logic        wr_ok,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);

	uht_wr_t wr_r;

	// a write fires once both address and data are held and no response waits
	assign wr_en = ce && !awready && !wready && !bvalid;
	assign wr    = wr_r;

	// write side, address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			wr_r    <= '0;
		end
		else if (ce)
		begin
			if (awvalid && awready)
			begin
				awready    <= 1'b0;
				wr_r.addr  <= awaddr;
			end
			if (wvalid && wready)
			begin
				wready     <= 1'b0;
				wr_r.data  <= wdata;
				wr_r.strb  <= wstrb;
			end
			if (wr_en)
			begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read side, data muxed from the live address in the taking cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_data;
				rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid && rready)
			begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

//--- bench/uht_link_model.sv
// link partner model: takes one token at a time and reports its finish
module uht_link_model
	import uht_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// token link
	input  wire uht_token_t tok,
	input  wire logic       tok_valid,
	output logic            tok_ready,
	output logic            tok_done,
	output logic [1:0]      tok_hs,
	output logic            tok_rx_tog_valid,
	output logic            tok_rx_tog,
	// behaviour chosen by the bench
	input  wire logic [3:0] lat,
	input  wire logic [1:0] hs_set,
	input  wire logic       rx_tog_set,
	// what was seen
	output uht_token_t      last_tok,
	output int              tok_count
);
	timeunit 1ns;
	timeprecision 1ns;

	logic       busy_r;
	logic [3:0] cnt_r;

	// result lines wander outside the done pulse so stale values are never trusted
	always_ff @(posedge aclk)
	begin
		tok_done <= 1'b0;
		tok_rx_tog_valid <= 1'b0;
		tok_hs <= ~tok_hs;
		tok_rx_tog <= ~tok_rx_tog;
		if (!aresetn)
		begin
			tok_ready <= 1'b0;
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			tok_count <= 0;
			last_tok <= '0;
			tok_hs <= 2'h0;
			tok_rx_tog <= 1'b0;
		end
		else if (tok_valid && tok_ready)
		begin
			tok_ready <= 1'b0;
			last_tok <= tok;
			tok_count <= tok_count + 1;
			busy_r <= 1'b1;
			cnt_r <= lat;
		end
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
		else if (busy_r)
		begin
			busy_r <= 1'b0;
			tok_done <= 1'b1;
			tok_hs <= hs_set;
			tok_rx_tog <= rx_tog_set;
			tok_rx_tog_valid <= 1'b1;
		end
		else if (tok_valid)
			tok_ready <= 1'b1;
	end
endmodule

//--- bench/test_uht_host_token.sv
// self-checking bench of the host token issuing block
module test_uht_host_token
	import uht_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	localparam int FCNT = 50;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, con = 1, rx_tog_set = 0, ce = 1, seen = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0]  lat = 0;
	logic [1:0]  hs_set = 0, bresp, rresp, tok_hs;
	logic        awready, wready, bvalid, arready, rvalid, tok_valid, tok_ready, tok_done;
	logic        rx_tv, rx_t, fm_busy, irq;
	logic [10:0] frame_number;
	uht_token_t  tok, last_tok;
	int          tok_count, cnt, num_errors = 0, n_tests = 0;

	always #5 aclk = ~aclk;

	uht_host_token #(.FRAME_CNT(FCNT)) i_uht_host_token (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
		.s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
		.s_rvalid(rvalid), .s_rready(rready), .tok(tok), .tok_valid(tok_valid),
		.tok_ready(tok_ready), .tok_done(tok_done), .tok_hs(tok_hs),
		.tok_rx_tog_valid(rx_tv), .tok_rx_tog(rx_t), .connect_status(con),
		.frame_marker_busy(fm_busy), .frame_number(frame_number), .irq(irq));

	uht_link_model i_uht_link_model (.aclk(aclk), .aresetn(aresetn), .tok(tok),
		.tok_valid(tok_valid), .tok_ready(tok_ready), .tok_done(tok_done), .tok_hs(tok_hs),
		.tok_rx_tog_valid(rx_tv), .tok_rx_tog(rx_t), .lat(lat), .hs_set(hs_set),
		.rx_tog_set(rx_tog_set), .last_tok(last_tok), .tok_count(tok_count));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	// one axi4-lite write; address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		v = rdata;
		rready <= 1'b0;
		chk(rresp, er);
	endtask

	// poll the status register until the done flag shows, bounded
	task automatic wait_done();
		int n;
		n = 0;
		do
		begin
			rd(OFS_STATUS, d, RESP_OKAY);
			n++;
		end
		while (d[STAT_DONE] !== 1'b1 && n < 50);
		chk(d[STAT_DONE], 1'b1);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// frame timer tests take a few hundred cycles; the rest stay well below this span
	initial
	begin
		repeat (20000) @(posedge aclk);
		$display("watchdog expired");
		num_errors++;
		give_verdict();
	end

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_TOKEN, d, RESP_OKAY);
		chk(d, 32'(TOKEN_RST));
		wr(OFS_CTRL, 32'h2, RESP_OKAY);
		wr(OFS_MASK, 32'h3, RESP_OKAY);
		$display("reset and setup test done");
		// every real token code except the frame marker, with varied toggle, endpoint and link latency
		for (int i = 1; i < 7; i++)
		begin
			if (i == 4)
				continue;
			lat <= 4'(3 * i);
			rx_tog_set <= i[0];
			hs_set <= i[1:0];
			wr(OFS_TOKEN, {24'h0, i[0], i[2:0], 4'(15 - i)}, RESP_OKAY);
			wait_done();
			chk(last_tok, {i[2:0], 4'(15 - i), i[0]});
			rd(OFS_TOKEN, d, RESP_OKAY);
			chk(d, {24'h0, i[0], CODE_NONE, 4'(15 - i)});
			chk(irq, 1'b1);
			rd(OFS_STATE, d, RESP_OKAY);
			chk(d[3:2], i[1:0]);
			wr(OFS_STATUS, 32'h3, RESP_OKAY);
			repeat (30) @(posedge aclk);
			chk(irq, 1'b0);
		end
		$display("token code test done");
		// received toggle differs from the selected one
		rx_tog_set <= 1'b0;
		wr(OFS_TOKEN, {24'h0, 1'b1, CODE_IN, 4'h3}, RESP_OKAY);
		wait_done();
		chk(d[1:0], 2'h3);
		wr(OFS_STATUS, 32'h3, RESP_OKAY);
		wr(OFS_MASK, 32'h0, RESP_OKAY);
		repeat (30) @(posedge aclk);
		wr(OFS_TOKEN, {24'h0, 1'b0, CODE_OUT, 4'h1}, RESP_OKAY);
		wait_done();
		chk(irq, 1'b0);
		wr(OFS_STATUS, 32'h3, RESP_OKAY);
		wr(OFS_MASK, 32'h3, RESP_OKAY);
		$display("toggle error and mask test done");
		// idle and reserved codes, then a request while nothing is attached
		cnt = tok_count;
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_TOKEN, {24'h0, 1'b1, (k == 0) ? CODE_NONE : CODE_RSVD, 4'h9}, RESP_OKAY);
			repeat (10) @(posedge aclk);
			rd(OFS_TOKEN, d, RESP_OKAY);
			chk(d[6:4], CODE_NONE);
		end
		con <= 1'b0;
		wr(OFS_TOKEN, {24'h0, 1'b0, CODE_SETUP, 4'h2}, RESP_OKAY);
		repeat (10) @(posedge aclk);
		rd(OFS_STATUS, d, RESP_OKAY);
		chk(d, 32'h0);
		chk(tok_count, cnt);
		con <= 1'b1;
		wr(8'h18, 32'h1, RESP_SLVERR);
		rd(8'h18, d, RESP_SLVERR);
		$display("refused request test done");
		// frame markers from the wrap point of the frame number
		wr(OFS_FRAME, 32'h7ff, RESP_OKAY);
		wr(OFS_TOKEN, 32'hc5, RESP_OKAY);
		wait_done();
		chk(last_tok, {TK_SOF, 4'h0, 1'b0});
		chk(frame_number, 11'h000);
		cnt = tok_count;
		for (int n = 0; n < FCNT + 20 && tok_count == cnt; n++)
		begin
			@(posedge aclk);
			seen |= fm_busy;
		end
		repeat (10) @(posedge aclk);
		chk(tok_count, cnt + 1);
		chk(frame_number, 11'h001);
		chk(seen, 1'b1);
		chk(fm_busy, 1'b0);
		// a low clock enable must hold the frame timer, so no further marker may appear
		ce <= 1'b0;
		repeat (FCNT + 20) @(posedge aclk);
		chk(tok_count, cnt + 1);
		chk(frame_number, 11'h001);
		ce <= 1'b1;
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		cnt = tok_count;
		rd(OFS_FRAME, d, RESP_OKAY);
		chk(d, 32'(FRAME_RST));
		repeat (FCNT + 20) @(posedge aclk);
		chk(tok_count, cnt);
		rd(OFS_STATE, d, RESP_OKAY);
		chk(d[4], 1'b1);
		$display("frame marker and soft reset test done");
		give_verdict();
	end
endmodule
